// File: hdl/cpc_pkg.sv
/*
 * Package for the charge pump current register bank: word indices,
 * field positions, values after reset and the gain encoding.
 * Assumes a 32-bit APB slave where each register index takes one word.
 */
package cpc_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [9:0] IDX_INT_PUMP = 10'h028;
    localparam logic [9:0] IDX_EXT_PUMP = 10'h029;
    localparam logic [9:0] IDX_EXT_DOWN = 10'h02a;

    // Address layout
    localparam int ADDR_W = 12;
    localparam int WORD_LSB = 2;

    // Values after reset
    localparam logic [15:0] RST_INT_PUMP = 16'h101c;
    localparam logic [15:0] RST_EXT_PUMP = 16'h0810;
    localparam logic [15:0] RST_EXT_DOWN = 16'h0010;

    // Field positions in the internal-oscillator word
    localparam int INT_UP_LSB = 8;
    localparam int INT_GAIN_LSB = 6;

    // Field positions in the external-oscillator word
    localparam int EXT_UP_LSB = 7;
    localparam int EXT_GAIN_LSB = 5;
    localparam int INT_DN_LSB = 0;

    // Field position in the external down-current word
    localparam int EXT_DN_LSB = 0;

    // Field widths
    localparam int CUR_W = 5;
    localparam int GAIN_W = 2;
    localparam int BASE_W = 6;
    localparam int TOTAL_W = 9;

    // Gain codes; the multiplier is held in halves
    typedef enum logic [1:0] {
        CPC_GAIN_1X0 = 2'b00,
        CPC_GAIN_2X0 = 2'b01,
        CPC_GAIN_1X5 = 2'b10,
        CPC_GAIN_2X5 = 2'b11
    } cpc_gain_t;

    // Multiplier in halves for a gain code
    function automatic logic [2:0] cpc_gain_halves(input logic [1:0] code);
        logic [2:0] h;
        h = 3'h2;
        case (cpc_gain_t'(code))
            CPC_GAIN_1X0: h = 3'h2;
            CPC_GAIN_2X0: h = 3'h4;
            CPC_GAIN_1X5: h = 3'h3;
            CPC_GAIN_2X5: h = 3'h5;
            default: h = 3'h2;
        endcase
        return h;
    endfunction : cpc_gain_halves

    // Word index from a byte address
    function automatic logic [9:0] cpc_index(input logic [11:0] addr);
        return addr[11:2];
    endfunction : cpc_index

endpackage : cpc_pkg

// File: hdl/cpc_pump_calc.sv
/*
 * Registered charge pump setting for one oscillator path: base current
 * as the sum of up and down codes, total current after the gain.
 * Assumes code inputs come from flops on the same clock.
 */
`timescale 1ns/10ps
module cpc_pump_calc
    import cpc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] up_code,
    input wire logic [4:0] down_code,
    input wire logic [1:0] gain_code,
    output logic [5:0] base,
    output logic [8:0] total,
    output logic pump_off
);

    logic [5:0] next_base;

    // Sum of the two codes, in 156.25 uA steps
    assign next_base = {1'b0, up_code} + {1'b0, down_code};

    // Base, gained total in 78.125 uA steps, and tri-state flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base <= 6'h00;
            total <= 9'h000;
            pump_off <= 1'b1;
        end else begin
            base <= next_base;
            total <= 9'(next_base * cpc_gain_halves(gain_code));
            pump_off <= (up_code == 5'h00) && (down_code == 5'h00);
        end
    end

    property p_base_sum;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> base == 6'($past(up_code) + $past(down_code));
    endproperty
    a_base_sum: assert property (p_base_sum)
        else $error("pump base is not the sum of up and down codes");

    property p_total_gain;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |->
        total == 9'(base * cpc_gain_halves($past(gain_code)));
    endproperty
    a_total_gain: assert property (p_total_gain)
        else $error("pump total does not follow the gain multiplier");

    property p_off_zero;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> (pump_off == (base == 6'h00));
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("tri-state flag disagrees with zero codes");

endmodule : cpc_pump_calc

// File: hdl/cpc_regs.sv
/*
 * Charge pump current register bank behind an APB slave, with the
 * registered pump settings for the external and internal oscillator.
 * Assumes a 10 MHz pclk, asynchronous active-low presetn and a master
 * that keeps to the APB protocol.
 */
`timescale 1ns/10ps
module cpc_regs
    import cpc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [4:0] ext_osc_up_current,
    output logic [4:0] ext_osc_down_current,
    output logic [1:0] ext_osc_pump_gain,
    output logic [4:0] int_osc_up_current,
    output logic [4:0] int_osc_down_current,
    output logic [1:0] int_osc_pump_gain,
    output logic [5:0] ext_pump_base,
    output logic [8:0] ext_pump_total,
    output logic ext_pump_off,
    output logic [5:0] int_pump_base,
    output logic [8:0] int_pump_total,
    output logic int_pump_off
);

    // Register words
    logic [15:0] int_pump_word;
    logic [15:0] ext_pump_word;
    logic [15:0] ext_down_word;

    // Bus decode
    logic [9:0] word_index;
    logic access_phase;
    logic access_done;
    logic write_done;
    logic hit_int;
    logic hit_ext;
    logic hit_down;
    logic addr_mapped;
    logic [31:0] next_rdata;

    // Word index and phase of the current transfer
    assign word_index = cpc_index(paddr);
    assign access_phase = psel && penable;
    assign access_done = access_phase && pready;
    assign write_done = access_done && pwrite;

    // Address decode
    assign hit_int = (word_index == IDX_INT_PUMP);
    assign hit_ext = (word_index == IDX_EXT_PUMP);
    assign hit_down = (word_index == IDX_EXT_DOWN);
    assign addr_mapped = hit_int || hit_ext || hit_down;

    // Merge of write data into a 16-bit word by byte lanes
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_word,
        input logic [31:0] wdata,
        input logic [3:0] strb
    );
        logic [15:0] w;
        w = old_word;
        if (strb[0]) begin
            w[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            w[15:8] = wdata[15:8];
        end
        return w;
    endfunction : lane_merge

    // Read multiplexer; unmapped words read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_int) begin
            next_rdata = {16'h0000, int_pump_word};
        end else if (hit_ext) begin
            next_rdata = {16'h0000, ext_pump_word};
        end else if (hit_down) begin
            next_rdata = {16'h0000, ext_down_word};
        end
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access_phase && !pready;
        end
    end

    // Read data and error flag are loaded as ready rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access_phase && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= !addr_mapped;
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Internal-oscillator word: up current, gain, writable low bits with no output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_pump_word <= RST_INT_PUMP;
        end else if (write_done && hit_int) begin
            int_pump_word <=
                lane_merge(int_pump_word, pwdata, pstrb);
        end
    end

    // External-oscillator word: up current, gain, internal down current
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pump_word <= RST_EXT_PUMP;
        end else if (write_done && hit_ext) begin
            ext_pump_word <=
                lane_merge(ext_pump_word, pwdata, pstrb);
        end
    end

    // External-oscillator down current word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_down_word <= RST_EXT_DOWN;
        end else if (write_done && hit_down) begin
            ext_down_word <= lane_merge(ext_down_word, pwdata, pstrb);
        end
    end

    // Field outputs are slices of the register flops
    assign ext_osc_up_current =
        ext_pump_word[EXT_UP_LSB +: CUR_W];
    assign ext_osc_pump_gain =
        ext_pump_word[EXT_GAIN_LSB +: GAIN_W];
    assign int_osc_down_current =
        ext_pump_word[INT_DN_LSB +: CUR_W];
    assign int_osc_up_current =
        int_pump_word[INT_UP_LSB +: CUR_W];
    assign int_osc_pump_gain =
        int_pump_word[INT_GAIN_LSB +: GAIN_W];
    assign ext_osc_down_current = ext_down_word[EXT_DN_LSB +: CUR_W];

    // External path in PLL mode; base is up plus down
    cpc_pump_calc u_ext_calc (
        .pclk(pclk),
        .presetn(presetn),
        .up_code(ext_osc_up_current),
        .down_code(ext_osc_down_current),
        .gain_code(ext_osc_pump_gain),
        .base(ext_pump_base),
        .total(ext_pump_total),
        .pump_off(ext_pump_off)
    );

    // Internal path in synthesizer mode
    cpc_pump_calc u_int_calc (
        .pclk(pclk),
        .presetn(presetn),
        .up_code(int_osc_up_current),
        .down_code(int_osc_down_current),
        .gain_code(int_osc_pump_gain),
        .base(int_pump_base),
        .total(int_pump_total),
        .pump_off(int_pump_off)
    );

    // Full-width write to the internal word is read back unchanged
    property p_int_write;
        @(posedge pclk) disable iff (!presetn)
        (write_done && hit_int && pstrb[1:0] == 2'b11) |=>
        (int_pump_word == $past(pwdata[15:0]));
    endproperty
    a_int_write: assert property (p_int_write)
        else $error("internal pump word did not take the write");

    // External up-current field lands in bits 11:7
    property p_ext_up;
        @(posedge pclk) disable iff (!presetn)
        (write_done && hit_ext && pstrb[1:0] == 2'b11) |=>
        (ext_osc_up_current == $past(pwdata[11:7]));
    endproperty
    a_ext_up: assert property (p_ext_up)
        else $error("external up current not taken from bits 11:7");

    // External gain field lands in bits 6:5
    property p_ext_gain;
        @(posedge pclk) disable iff (!presetn)
        (write_done && hit_ext && pstrb[0]) |=>
        (ext_osc_pump_gain == $past(pwdata[6:5]));
    endproperty
    a_ext_gain: assert property (p_ext_gain)
        else $error("external gain not taken from bits 6:5");

    // Internal up current and gain fields of the internal word
    property p_int_fields;
        @(posedge pclk) disable iff (!presetn)
        (write_done && hit_int && pstrb[1:0] == 2'b11) |=>
        (int_osc_up_current == $past(pwdata[12:8])) &&
        (int_osc_pump_gain == $past(pwdata[7:6]));
    endproperty
    a_int_fields: assert property (p_int_fields)
        else $error("internal up current or gain field misplaced");

    // Internal down current comes from bits 4:0 of the external word
    property p_int_down;
        @(posedge pclk) disable iff (!presetn)
        (write_done && hit_ext && pstrb[0]) |=>
        (int_osc_down_current == $past(pwdata[4:0]));
    endproperty
    a_int_down: assert property (p_int_down)
        else $error("internal down current not taken from bits 4:0");

    // Read of the external word returns its stored value
    property p_ext_read;
        @(posedge pclk) disable iff (!presetn)
        (access_done && !pwrite && hit_ext) |->
        (prdata == {16'h0000, ext_pump_word});
    endproperty
    a_ext_read: assert property (p_ext_read)
        else $error("external word readback mismatch");

    // Ready follows the first access cycle by exactly one cycle
    property p_ready_wait;
        @(posedge pclk) disable iff (!presetn)
        (access_phase && !pready) |=> pready ##1 !pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("ready not a single pulse after one wait state");

    // Ready stays low when no access phase is under way
    property p_ready_idle;
        @(posedge pclk) disable iff (!presetn)
        !access_phase |=> !pready;
    endproperty
    a_ready_idle: assert property (p_ready_idle)
        else $error("ready raised outside an access phase");

    // Full-width write to the external word is read back unchanged
    property p_ext_write;
        @(posedge pclk) disable iff (!presetn)
        (write_done && hit_ext && pstrb[1:0] == 2'b11) |=>
        (ext_pump_word == $past(pwdata[15:0]));
    endproperty
    a_ext_write: assert property (p_ext_write)
        else $error("external pump word did not take the write");

    // Read of the internal word returns its stored value
    property p_int_read;
        @(posedge pclk) disable iff (!presetn)
        (access_done && !pwrite && hit_int) |->
        (prdata == {16'h0000, int_pump_word});
    endproperty
    a_int_read: assert property (p_int_read)
        else $error("internal word readback mismatch");

    // Pump words come out of reset at their documented values
    property p_reset_words;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |->
        (int_pump_word == RST_INT_PUMP) && (ext_pump_word == RST_EXT_PUMP);
    endproperty
    a_reset_words: assert property (p_reset_words)
        else $error("register words not at reset values after reset");

    // Error flag marks exactly the unmapped words
    property p_slverr_map;
        @(posedge pclk) disable iff (!presetn)
        access_done |-> (pslverr == !addr_mapped);
    endproperty
    a_slverr_map: assert property (p_slverr_map)
        else $error("error flag disagrees with the address decode");

    // A write to an unmapped word leaves both pump words alone
    property p_unmapped_keep;
        @(posedge pclk) disable iff (!presetn)
        (write_done && !addr_mapped) |=>
        $stable(int_pump_word) && $stable(ext_pump_word);
    endproperty
    a_unmapped_keep: assert property (p_unmapped_keep)
        else $error("unmapped write changed a pump word");

    c_write_ext: cover property (@(posedge pclk) disable iff (!presetn)
        write_done && hit_ext);
    c_read_int: cover property (@(posedge pclk) disable iff (!presetn)
        access_done && !pwrite && hit_int);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
        access_done && pslverr);
    c_gain_max: cover property (@(posedge pclk) disable iff (!presetn)
        ext_osc_pump_gain == 2'b11 && ext_pump_total != 9'h000);
    c_byte_write: cover property (@(posedge pclk) disable iff (!presetn)
        write_done && hit_int && pstrb[1:0] == 2'b01);

endmodule : cpc_regs

// File: bench/testbench.sv
/*
 * Self-checking bench for the charge pump current register bank.
 * Assumes the cpc_regs APB slave with one wait state and the
 * registered field, base and total outputs of cpc_regs.
 */
`timescale 1ns/10ps
module testbench
    import cpc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, er;
    logic [4:0] eu, ed, iu, idn;
    logic [1:0] eg, ig;
    logic [5:0] eb, ib;
    logic [8:0] et, it;
    logic eo, io;
    logic [15:0] w28, w29, w2a;
    int err_total, num_checks;
    typedef struct {
        logic [11:0] a;
        logic [15:0] d;
        logic [8:0] xt;
        logic [8:0] yt;
    } cpc_row_t;
    // Address, data, then external and internal pump totals expected
    // Up/down pairs equal once both are written
    // Reserved bits zero, internal low bits 0x1c
    cpc_row_t rows [12] = '{
        '{12'h0a4, 16'h0f7f, 9'h0e6, 9'h05e},
        '{12'h0a8, 16'h001e, 9'h12c, 9'h05e},
        '{12'h0a0, 16'h1f5c, 9'h12c, 9'h0f8},
        '{12'h0a4, 16'h0121, 9'h080, 9'h080},
        '{12'h0a8, 16'h0002, 9'h010, 9'h080},
        '{12'h0a0, 16'h019c, 9'h010, 9'h006},
        '{12'h0a4, 16'h0040, 9'h006, 9'h003},
        '{12'h0a8, 16'h0000, 9'h000, 9'h003},
        '{12'h0a0, 16'h001c, 9'h000, 9'h000},
        '{12'h0a0, 16'h10dc, 9'h000, 9'h050},
        '{12'h0a4, 16'h0810, 9'h020, 9'h0a0},
        '{12'h0a8, 16'h0010, 9'h040, 9'h0a0}
    };

    cpc_regs u_cpc_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_osc_up_current(eu), .ext_osc_down_current(ed),
        .ext_osc_pump_gain(eg), .int_osc_up_current(iu),
        .int_osc_down_current(idn), .int_osc_pump_gain(ig),
        .ext_pump_base(eb), .ext_pump_total(et), .ext_pump_off(eo),
        .int_pump_base(ib), .int_pump_total(it), .int_pump_off(io));

    // Clock, 100 ns period
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; returns just after the edge that completes it,
    // with the bus still held for the caller to release or reuse
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= wr ? s : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        // Values read here are those sampled at this rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) chk(32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
    endtask : apb

    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : idle

    function automatic logic [15:0] upd(input logic [15:0] o,
        input logic [15:0] d, input logic [3:0] s);
        return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : upd

    // Gain in halves; the real pump only approximates these
    function automatic logic [2:0] halves(input logic [1:0] g);
        case (g)
            2'h0: return 3'h2;
            2'h1: return 3'h4;
            2'h2: return 3'h3;
            default: return 3'h5;
        endcase
    endfunction : halves

    // Write with shadow update, then read back
    task automatic wr_rd(input logic [11:0] a, input logic [15:0] d,
        input logic [3:0] s);
        logic m;
        logic [15:0] ex;
        m = (a == 12'h0a0 || a == 12'h0a4 || a == 12'h0a8);
        apb(1'b1, a, {16'hffff, d}, s);
        chk(er, !m);
        if (a == 12'h0a0) w28 = upd(w28, d, s);
        if (a == 12'h0a4) w29 = upd(w29, d, s);
        if (a == 12'h0a8) w2a = upd(w2a, d, s);
        ex = !m ? 16'h0 : (a == 12'h0a0) ? w28 : (a == 12'h0a4) ? w29 : w2a;
        apb(1'b0, a, 32'h0, 4'hf);
        chk(er, !m);
        chk(rd, {16'h0, ex});
    endtask : wr_rd

    // Field and pump outputs against shadows
    task automatic outs;
        logic [5:0] xb, yb;
        logic [8:0] xt, yt;
        idle();
        @(posedge pclk);
        @(negedge pclk);
        xb = w29[11:7] + w2a[4:0];
        yb = w28[12:8] + w29[4:0];
        xt = 9'(xb * halves(w29[6:5]));
        yt = 9'(yb * halves(w28[7:6]));
        chk({eu, ed, eg}, {w29[11:7], w2a[4:0], w29[6:5]});
        chk({iu, idn}, {w28[12:8], w29[4:0]});
        chk(ig, w28[7:6]);
        chk({eb, et, eo}, {xb, xt, xb == 6'h0});
        chk({ib, it, io}, {yb, yt, yb == 6'h0});
        // Hand back just after a rising edge for the next request
        @(posedge pclk);
    endtask : outs

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        w28 = 16'h101c;
        w29 = 16'h0810;
        w2a = 16'h0010;
        @(posedge pclk);
    endtask : do_reset

    // Watchdog; the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        close_out();
    end

    // Main sequence
    initial begin
        err_total = 0;
        num_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        do_reset();
        apb(1'b0, 12'h0a0, 32'h0, 4'hf);
        chk(rd, 32'h101c);
        apb(1'b0, 12'h0a4, 32'h0, 4'hf);
        chk(rd, 32'h0810);
        outs();
        foreach (rows[i]) begin
            wr_rd(rows[i].a, rows[i].d, 4'hf);
            outs();
            chk({et, it}, {rows[i].xt, rows[i].yt});
        end
        // Unmapped places refuse and leave the words alone
        wr_rd(12'h0ac, 16'h5555, 4'hf);
        wr_rd(12'h09c, 16'h1234, 4'hf);
        outs();
        // Reserved bits written as zero, byte strobes, back to back
        wr_rd(12'h0a4, 16'h0810, 4'hf);
        wr_rd(12'h0a0, 16'hff9c, 4'h1);
        wr_rd(12'h0a0, 16'h0400, 4'h2);
        outs();
        // Reset in mid-run restores values
        do_reset();
        outs();
        apb(1'b0, 12'h0a8, 32'h0, 4'hf);
        chk(rd, 32'h0010);
        idle();
        close_out();
    end
endmodule : testbench
